// ==== src/asla_consts.svh ====
// Constants for the arming status and loop assignment slice
`ifndef ASLA_CONSTS_SVH
`define ASLA_CONSTS_SVH
`define ASLA_ADDR_ALGO_CONF     7'h66
`define ASLA_ADDR_ARM_STATUS    7'h6A
`define ASLA_ADDR_ARM1_LOOP     7'h6E
`define ASLA_ADDR_ARM2_LOOP     7'h6F
`define ASLA_ADDR_ARM1_STRETCH  7'h73
`define ASLA_RST_ALGO_CONF      16'h00CC
`define ASLA_RST_ARM1_LOOP      16'h00DC
`define ASLA_RST_ARM2_LOOP      16'h00DE
`define ASLA_FRAME_BITS         6'h20
`define ASLA_FRM_WRITE          31
`define ASLA_FRM_ADDR_HI        30
`define ASLA_FRM_ADDR_LO        24
`define ASLA_FRM_DATA_HI        15
`define ASLA_GOOD_LIMIT         2'h3
`define ASLA_BAD_LIMIT          2'h2
`define ASLA_CLK_MHZ            200
`define ASLA_TICK_US            2000
`define ASLA_ST_PIN_ECHO        7
`define ASLA_ST_VALID           6
`define ASLA_ST_ARMINT_HI       3
`define ASLA_ST_ARMINT_LO       2
`define ASLA_ST_EXT_LOW         1
`define ASLA_ST_EXT_HIGH        0
`define ASLA_SYNC_PINS          5
`endif

// ==== src/asla_crash_if.sv ====
// Crash input sample path between top and qualifier
`timescale 1ns/100ps
interface asla_crash_if;
  logic sample_strobe;
  logic sample_good;
  logic clear;
  logic valid;
  modport qual (input sample_strobe, sample_good, clear, output valid);
  modport top  (output sample_strobe, sample_good, clear, input valid);
endinterface : asla_crash_if

// ==== src/asla_crash_qual.sv ====
// Good/bad sample qualifier for the crash input validity flag
`timescale 1ns/100ps
`include "asla_consts.svh"
module asla_crash_qual
  import asla_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Sample path
  asla_crash_if.qual  crash
);
  logic [1:0] good_sample_count;
  logic [1:0] bad_sample_count;
  logic       valid;
  logic [1:0] next_good_sample_count;
  logic [1:0] next_bad_sample_count;
  logic       next_valid;

  always_comb begin
    next_good_sample_count = good_sample_count;
    next_bad_sample_count  = bad_sample_count;
    next_valid             = valid;
    if (crash.clear) begin
      next_good_sample_count = 2'h0;
      next_bad_sample_count  = 2'h0;
      next_valid             = 1'b0;
    end else if (crash.sample_strobe) begin
      if (crash.sample_good) begin
        next_bad_sample_count = 2'h0;
        if (good_sample_count != `ASLA_GOOD_LIMIT) begin
          next_good_sample_count = good_sample_count + 2'h1;
        end
        if (next_good_sample_count == `ASLA_GOOD_LIMIT) begin
          next_valid = 1'b1;
        end
      end else begin
        next_good_sample_count = 2'h0;
        if (bad_sample_count != `ASLA_BAD_LIMIT) begin
          next_bad_sample_count = bad_sample_count + 2'h1;
        end
        if (next_bad_sample_count == `ASLA_BAD_LIMIT) begin
          next_valid = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      good_sample_count <= 2'h0;
      bad_sample_count  <= 2'h0;
      valid             <= 1'b0;
    end else begin
      good_sample_count <= next_good_sample_count;
      bad_sample_count  <= next_bad_sample_count;
      valid             <= next_valid;
    end
  end

  assign crash.valid = valid;
endmodule : asla_crash_qual

// ==== src/asla_pkg.sv ====
// Types shared by the arming status and loop assignment slice
package asla_pkg;
  typedef enum logic [1:0] {
    ASLA_IDLE  = 2'b01,
    ASLA_SHIFT = 2'b10
  } asla_spi_state_t;
  typedef logic [15:0] asla_word_t;
endpackage : asla_pkg

// ==== src/asla_top.sv ====
// Arming status, loop assignment and stretch timer with SPI access
// Overview of operation
// - Validity flag sets after three good samples
// - Validity flag clears after two bad samples
// - Status bits 1,0 echo external arm pins
// - Status bits 3,2 show internal arm signals
// - Loop bits tie arm line to loops
// - Loop writes only in diagnostic state
// - Stretch timer cleared, decremented every 2 ms
`timescale 1ns/100ps
`include "asla_consts.svh"
module asla_top
  import asla_pkg::*;
#(
  parameter int TICK_CYCLES = `ASLA_TICK_US * `ASLA_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  // SPI pins
  input  wire logic        SPI_SCLK,
  input  wire logic        SPI_CS_N,
  input  wire logic        SPI_MOSI,
  output logic             SPI_MISO,
  output logic             SPI_MISO_OE,
  // External pins
  input  wire logic        CRASH_PIN,
  input  wire logic        EXTERNAL_ARM_HIGH,
  input  wire logic        EXTERNAL_ARM_LOW,
  // Safing engine side
  input  wire logic [1:0]  ARM_INTERNAL,
  input  wire logic        DIAGNOSTIC_STATE,
  input  wire logic        SAFING_STATE_RESET,
  input  wire logic        CRASH_SAMPLE_STROBE,
  input  wire logic        CRASH_SAMPLE_GOOD,
  input  wire logic        STRETCH_LOAD,
  input  wire logic [9:0]  STRETCH_LOAD_VALUE,
  // Outputs to deployment logic
  output logic [3:0]       ARM1_LOOP_LINK,
  output logic [3:0]       ARM2_LOOP_LINK,
  output logic [15:0]      ALGO_CONFIG,
  output logic [9:0]       STRETCH_COUNT,
  output logic             CRASH_INPUT_VALID
);
  localparam logic [18:0] TICK_LAST = 19'(TICK_CYCLES - 1);

  // Two-stage sync of all pins but chip select; stage one feeds stage two only
  logic [`ASLA_SYNC_PINS-1:0] pin_raw;
  logic [`ASLA_SYNC_PINS-1:0] pin_meta;
  logic [`ASLA_SYNC_PINS-1:0] pin_sync;
  assign pin_raw = {CRASH_PIN, EXTERNAL_ARM_LOW, EXTERNAL_ARM_HIGH,
                    SPI_MOSI, SPI_SCLK};
  genvar gi;
  generate
    for (gi = 0; gi < `ASLA_SYNC_PINS; gi++) begin : g_sync
      always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // Chip select idles high, so it gets its own sync pair
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic sclk_prev;
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      cs_meta   <= 1'b1;
      cs_sync   <= 1'b1;
      cs_prev   <= 1'b1;
      sclk_prev <= 1'b0;
    end else begin
      cs_meta   <= SPI_CS_N;
      cs_sync   <= cs_meta;
      cs_prev   <= cs_sync;
      sclk_prev <= pin_sync[0];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_start;
  logic cs_end;
  assign sclk_rise = pin_sync[0] & ~sclk_prev;
  assign sclk_fall = ~pin_sync[0] & sclk_prev;
  assign cs_start  = cs_prev & ~cs_sync;
  assign cs_end    = ~cs_prev & cs_sync;

  // Register state
  logic [3:0]       arm1_loop;
  logic [3:0]       arm2_loop;
  asla_word_t       algo_conf;
  logic [9:0]       stretch;
  logic [18:0]      tick_cnt;
  logic [3:0]       next_arm1_loop;
  logic [3:0]       next_arm2_loop;
  asla_word_t       next_algo_conf;
  logic [9:0]       next_stretch;
  logic [18:0]      next_tick_cnt;
  logic             local_rst_n;
  assign local_rst_n = RESET_N & ~SAFING_STATE_RESET;

  // SPI state
  asla_spi_state_t  spi_state;
  asla_spi_state_t  next_spi_state;
  logic [31:0]      rx_shift;
  logic [31:0]      tx_shift;
  logic [31:0]      reply;
  logic [5:0]       bit_cnt;
  logic             miso;
  logic             miso_oe;
  logic [31:0]      next_rx_shift;
  logic [31:0]      next_tx_shift;
  logic [31:0]      next_reply;
  logic [5:0]       next_bit_cnt;
  logic             next_miso;
  logic             next_miso_oe;

  asla_crash_if crash ();
  assign crash.sample_strobe = CRASH_SAMPLE_STROBE;
  assign crash.sample_good   = CRASH_SAMPLE_GOOD;
  assign crash.clear         = SAFING_STATE_RESET;

  asla_crash_qual u_qual (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .crash (crash.qual)
  );

  // Read decode for the reply word; unknown addresses read as zero
  function automatic asla_word_t read_word(input logic [6:0] addr);
    asla_word_t w;
    w = 16'h0000;
    case (addr)
      `ASLA_ADDR_ALGO_CONF:    w = algo_conf;
      `ASLA_ADDR_ARM_STATUS: begin
        w[`ASLA_ST_PIN_ECHO] = pin_sync[4];
        w[`ASLA_ST_VALID]    = crash.valid;
        w[`ASLA_ST_ARMINT_HI:`ASLA_ST_ARMINT_LO] = ARM_INTERNAL;
        w[`ASLA_ST_EXT_LOW]  = pin_sync[3];
        w[`ASLA_ST_EXT_HIGH] = pin_sync[2];
      end
      `ASLA_ADDR_ARM1_LOOP:    w[3:0] = arm1_loop;
      `ASLA_ADDR_ARM2_LOOP:    w[3:0] = arm2_loop;
      `ASLA_ADDR_ARM1_STRETCH: w[9:0] = stretch;
      default:                 w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  logic        frame_done;
  logic        frame_write;
  logic [6:0]  frame_addr;
  asla_word_t  frame_data;
  assign frame_done  = cs_end && (bit_cnt == `ASLA_FRAME_BITS);
  assign frame_write = rx_shift[`ASLA_FRM_WRITE];
  assign frame_addr  = rx_shift[`ASLA_FRM_ADDR_HI:`ASLA_FRM_ADDR_LO];
  assign frame_data  = rx_shift[`ASLA_FRM_DATA_HI:0];

  always_comb begin
    next_spi_state = spi_state;
    next_rx_shift  = rx_shift;
    next_tx_shift  = tx_shift;
    next_reply     = reply;
    next_bit_cnt   = bit_cnt;
    next_miso      = miso;
    next_miso_oe   = miso_oe;
    case (spi_state)
      ASLA_IDLE: begin
        next_miso_oe = 1'b0;
        if (cs_start) begin
          next_spi_state = ASLA_SHIFT;
          next_bit_cnt   = 6'h00;
          next_miso      = reply[31];
          next_tx_shift  = {reply[30:0], 1'b0};
          next_miso_oe   = 1'b1;
        end
      end
      ASLA_SHIFT: begin
        if (sclk_rise && bit_cnt != `ASLA_FRAME_BITS) begin
          next_rx_shift = {rx_shift[30:0], pin_sync[1]};
          next_bit_cnt  = bit_cnt + 6'h01;
        end
        if (sclk_fall && bit_cnt != 6'h00) begin
          next_miso     = tx_shift[31];
          next_tx_shift = {tx_shift[30:0], 1'b0};
        end
        if (cs_end) begin
          next_spi_state = ASLA_IDLE;
          next_miso_oe   = 1'b0;
          next_miso      = 1'b0;
          // Short frames are dropped whole
          if (frame_done) begin
            next_reply = {1'b0, frame_addr, 8'h00, read_word(frame_addr)};
          end
        end
      end
      default: begin
        next_spi_state = ASLA_IDLE;
        next_miso_oe   = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_arm1_loop = arm1_loop;
    next_arm2_loop = arm2_loop;
    next_algo_conf = algo_conf;
    next_stretch   = stretch;
    next_tick_cnt  = tick_cnt;
    if (frame_done && frame_write && DIAGNOSTIC_STATE) begin
      case (frame_addr)
        `ASLA_ADDR_ARM1_LOOP: next_arm1_loop = frame_data[3:0];
        `ASLA_ADDR_ARM2_LOOP: next_arm2_loop = frame_data[3:0];
        `ASLA_ADDR_ALGO_CONF: next_algo_conf = frame_data;
        default:              next_algo_conf = algo_conf;
      endcase
    end
    if (stretch != 10'h000) begin
      if (tick_cnt == TICK_LAST) begin
        next_tick_cnt = 19'h00000;
        next_stretch  = stretch - 10'h001;
      end else begin
        next_tick_cnt = tick_cnt + 19'h00001;
      end
    end else begin
      next_tick_cnt = 19'h00000;
    end
    // Load only raises the count, never shortens it
    if (STRETCH_LOAD && STRETCH_LOAD_VALUE > stretch) begin
      next_stretch  = STRETCH_LOAD_VALUE;
      next_tick_cnt = 19'h00000;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      spi_state <= ASLA_IDLE;
      rx_shift  <= 32'h00000000;
      tx_shift  <= 32'h00000000;
      reply     <= 32'h00000000;
      bit_cnt   <= 6'h00;
      miso      <= 1'b0;
      miso_oe   <= 1'b0;
    end else begin
      spi_state <= next_spi_state;
      rx_shift  <= next_rx_shift;
      tx_shift  <= next_tx_shift;
      reply     <= next_reply;
      bit_cnt   <= next_bit_cnt;
      miso      <= next_miso;
      miso_oe   <= next_miso_oe;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!local_rst_n) begin
      arm1_loop <= 4'(`ASLA_RST_ARM1_LOOP);
      arm2_loop <= 4'(`ASLA_RST_ARM2_LOOP);
      algo_conf <= `ASLA_RST_ALGO_CONF;
      stretch   <= 10'h000;
      tick_cnt  <= 19'h00000;
    end else begin
      arm1_loop <= next_arm1_loop;
      arm2_loop <= next_arm2_loop;
      algo_conf <= next_algo_conf;
      stretch   <= next_stretch;
      tick_cnt  <= next_tick_cnt;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      ARM1_LOOP_LINK    <= 4'h0;
      ARM2_LOOP_LINK    <= 4'h0;
      ALGO_CONFIG       <= 16'h0000;
      STRETCH_COUNT     <= 10'h000;
      CRASH_INPUT_VALID <= 1'b0;
    end else begin
      ARM1_LOOP_LINK    <= arm1_loop;
      ARM2_LOOP_LINK    <= arm2_loop;
      ALGO_CONFIG       <= algo_conf;
      STRETCH_COUNT     <= stretch;
      CRASH_INPUT_VALID <= crash.valid;
    end
  end

  assign SPI_MISO    = miso;
  assign SPI_MISO_OE = miso_oe;
endmodule : asla_top

// ==== tb/asla_spi_host.sv ====
// Behavioural SPI host framing 32-bit words for the slice
`timescale 1ns/100ps
module asla_spi_host (
  // Clock
  input  wire logic ref_clk,
  // SPI pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // Half period kept above the pin sync depth
  localparam int HALF = 6;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    @(negedge ref_clk);
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      repeat (HALF) @(negedge ref_clk);
      sclk = 1'b1;
      rx[i] = miso;
      repeat (HALF) @(negedge ref_clk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge ref_clk);
    cs_n = 1'b1;
    // Released line must not keep the last bit
    mosi = ~mosi;
    repeat (8) @(negedge ref_clk);
  endtask : xfer
endmodule : asla_spi_host

// ==== tb/asla_top_asserts.sv ====
// Port checks for the arming status slice
`timescale 1ns/100ps
module asla_top_asserts
  import asla_pkg::*;
#(
  parameter int TICK_CYCLES = 8
) (
  input wire logic       REF_CLK,
  input wire logic       RESET_N,
  input wire logic       SPI_MISO_OE,
  input wire logic       DIAGNOSTIC_STATE,
  input wire logic       SAFING_STATE_RESET,
  input wire logic       CRASH_SAMPLE_STROBE,
  input wire logic       CRASH_SAMPLE_GOOD,
  input wire logic       STRETCH_LOAD,
  input wire logic [3:0] ARM1_LOOP_LINK,
  input wire logic [3:0] ARM2_LOOP_LINK,
  input wire logic [15:0] ALGO_CONFIG,
  input wire logic [9:0] STRETCH_COUNT,
  input wire logic       CRASH_INPUT_VALID
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  logic [2:0]  up;
  logic [31:0] gap;
  logic [9:0]  last;
  logic        was_dec;
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
    last <= STRETCH_COUNT;
    gap <= (STRETCH_COUNT != last) ? 32'h1 : gap + 32'h1;
    if (STRETCH_COUNT != last) was_dec <= (STRETCH_COUNT == last - 10'h1);
  end
  sequence good_s;
    CRASH_SAMPLE_STROBE && CRASH_SAMPLE_GOOD && !SAFING_STATE_RESET;
  endsequence
  sequence bad_s;
    CRASH_SAMPLE_STROBE && !CRASH_SAMPLE_GOOD;
  endsequence
  sequence dec_s;
    up == 3'h7 && $changed(STRETCH_COUNT) && !$past(STRETCH_LOAD)
      && !$past(STRETCH_LOAD, 2) && !$past(SAFING_STATE_RESET, 2);
  endsequence
  a_reset_clear:
    assert property (disable iff (1'b0) !RESET_N |=> !SPI_MISO_OE
      && !CRASH_INPUT_VALID && STRETCH_COUNT == 10'h0)
      else $error("outputs not cleared by reset");
  a_valid_set:
    assert property (good_s [*3] ##1 !SAFING_STATE_RESET [*2]
      |-> CRASH_INPUT_VALID) else $error("valid flag not set");
  a_valid_clear:
    assert property (bad_s [*2] |-> ##2 !CRASH_INPUT_VALID)
      else $error("valid flag not cleared");
  a_loop_hold:
    assert property (up == 3'h7 && ($changed(ARM1_LOOP_LINK)
      || $changed(ARM2_LOOP_LINK) || $changed(ALGO_CONFIG))
      |-> $past(DIAGNOSTIC_STATE, 2) || $past(SAFING_STATE_RESET, 2)
      || $past(SAFING_STATE_RESET)) else $error("config changed outside diagnostic_state");
  a_ssr_defaults:
    assert property (SAFING_STATE_RESET && !DIAGNOSTIC_STATE
      ##1 !DIAGNOSTIC_STATE |-> ##1 ARM1_LOOP_LINK == 4'hC
      && ARM2_LOOP_LINK == 4'hE && ALGO_CONFIG == 16'h00CC)
      else $error("defaults not restored");
  a_stretch_clear:
    assert property (SAFING_STATE_RESET && !STRETCH_LOAD ##1 !STRETCH_LOAD
      |-> ##1 STRETCH_COUNT == 10'h0) else $error("timer not cleared");
  a_stretch_step:
    assert property (dec_s |-> STRETCH_COUNT == $past(STRETCH_COUNT) - 10'h1)
      else $error("timer step wrong");
  a_stretch_period:
    assert property (dec_s ##0 was_dec |-> gap == TICK_CYCLES)
      else $error("timer period wrong");
endmodule : asla_top_asserts
bind asla_top asla_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .REF_CLK, .RESET_N, .SPI_MISO_OE, .DIAGNOSTIC_STATE,
  .SAFING_STATE_RESET, .CRASH_SAMPLE_STROBE, .CRASH_SAMPLE_GOOD,
  .STRETCH_LOAD, .ARM1_LOOP_LINK, .ARM2_LOOP_LINK, .ALGO_CONFIG,
  .STRETCH_COUNT, .CRASH_INPUT_VALID);

// ==== tb/tb_top.sv ====
// Self-checking bench for the arming status slice
`timescale 1ns/100ps
module tb_top;
  import asla_pkg::*;
  localparam int TICK = 8;
  logic        REF_CLK = 1'b0, RESET_N = 1'b0;
  logic        SPI_SCLK, SPI_CS_N, SPI_MOSI, SPI_MISO, SPI_MISO_OE;
  logic        CRASH_PIN = 1'b0, DIAGNOSTIC_STATE = 1'b0;
  logic        EXTERNAL_ARM_HIGH = 1'b0, EXTERNAL_ARM_LOW = 1'b0;
  logic [1:0]  ARM_INTERNAL = 2'h0;
  logic        SAFING_STATE_RESET = 1'b0, STRETCH_LOAD = 1'b0;
  logic        CRASH_SAMPLE_STROBE = 1'b0, CRASH_SAMPLE_GOOD = 1'b0;
  logic [9:0]  STRETCH_LOAD_VALUE = 10'h0, STRETCH_COUNT;
  logic [3:0]  ARM1_LOOP_LINK, ARM2_LOOP_LINK;
  logic [15:0] ALGO_CONFIG;
  logic        CRASH_INPUT_VALID;
  int          mismatches = 0, samples_checked = 0, cycles = 0;
  asla_top #(.TICK_CYCLES(TICK)) dut (.REF_CLK, .RESET_N, .SPI_SCLK,
    .SPI_CS_N, .SPI_MOSI, .SPI_MISO, .SPI_MISO_OE, .CRASH_PIN,
    .EXTERNAL_ARM_HIGH, .EXTERNAL_ARM_LOW, .ARM_INTERNAL,
    .DIAGNOSTIC_STATE, .SAFING_STATE_RESET, .CRASH_SAMPLE_STROBE,
    .CRASH_SAMPLE_GOOD, .STRETCH_LOAD, .STRETCH_LOAD_VALUE,
    .ARM1_LOOP_LINK, .ARM2_LOOP_LINK, .ALGO_CONFIG, .STRETCH_COUNT,
    .CRASH_INPUT_VALID);
  asla_spi_host host (.ref_clk(REF_CLK), .sclk(SPI_SCLK),
    .cs_n(SPI_CS_N), .mosi(SPI_MOSI), .miso(SPI_MISO));
  always #2.5 REF_CLK = ~REF_CLK;
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask : cyc
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [31:0] rx;
    host.xfer({1'b1, a, 8'hFF, d}, rx);
  endtask : wr
  // Reply comes out in the following frame
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    logic [31:0] rx;
    host.xfer({1'b0, a, 24'h0}, rx);
    host.xfer(32'h0, rx);
    chk("read", rx, {1'b0, a, 8'h00, e});
  endtask : rd
  task automatic burst(input int n, input logic g);
    CRASH_SAMPLE_STROBE = 1'b1;
    CRASH_SAMPLE_GOOD = g;
    cyc(n);
    CRASH_SAMPLE_STROBE = 1'b0;
    cyc(3);
  endtask : burst
  task automatic t_defaults();
    chk("arm1", ARM1_LOOP_LINK, 32'hC);
    chk("arm2", ARM2_LOOP_LINK, 32'hE);
    chk("algo", ALGO_CONFIG, 32'hCC);
    chk("valid", CRASH_INPUT_VALID, 32'h0);
    chk("stretch", STRETCH_COUNT, 32'h0);
    rd(7'h6E, 16'h000C);
    rd(7'h6F, 16'h000E);
    rd(7'h66, 16'h00CC);
  endtask : t_defaults
  task automatic t_loops();
    wr(7'h6E, 16'hFFF5);
    chk("arm1 locked", ARM1_LOOP_LINK, 32'hC);
    DIAGNOSTIC_STATE = 1'b1;
    wr(7'h6E, 16'hFFF5);
    wr(7'h6F, 16'h000A);
    wr(7'h6A, 16'hFFFF);
    wr(7'h66, 16'h1234);
    chk("algo", ALGO_CONFIG, 32'h1234);
    chk("arm1", ARM1_LOOP_LINK, 32'h5);
    chk("arm2", ARM2_LOOP_LINK, 32'hA);
    rd(7'h6E, 16'h0005);
    DIAGNOSTIC_STATE = 1'b0;
    SAFING_STATE_RESET = 1'b1;
    cyc(1);
    SAFING_STATE_RESET = 1'b0;
    cyc(3);
    chk("arm1 ssr", ARM1_LOOP_LINK, 32'hC);
    chk("arm2 ssr", ARM2_LOOP_LINK, 32'hE);
    chk("algo ssr", ALGO_CONFIG, 32'hCC);
  endtask : t_loops
  task automatic t_crash();
    burst(2, 1'b1);
    chk("two good", CRASH_INPUT_VALID, 32'h0);
    burst(1, 1'b1);
    chk("third good", CRASH_INPUT_VALID, 32'h1);
    burst(1, 1'b0);
    chk("one bad", CRASH_INPUT_VALID, 32'h1);
    burst(1, 1'b0);
    chk("two bad", CRASH_INPUT_VALID, 32'h0);
    burst(3, 1'b1);
    chk("good run", CRASH_INPUT_VALID, 32'h1);
    burst(2, 1'b0);
    chk("bad run", CRASH_INPUT_VALID, 32'h0);
    burst(3, 1'b1);
  endtask : t_crash
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      EXTERNAL_ARM_HIGH = i[0];
      EXTERNAL_ARM_LOW = i[1];
      ARM_INTERNAL = ~i[1:0];
      CRASH_PIN = i[0];
      cyc(8);
      rd(7'h6A, {8'h00, i[0], 3'b100, ~i[1:0], i[1], i[0]});
    end
    rd(7'h10, 16'h0000);
  endtask : t_status
  task automatic t_stretch();
    STRETCH_LOAD_VALUE = 10'h005;
    STRETCH_LOAD = 1'b1;
    cyc(1);
    STRETCH_LOAD = 1'b0;
    cyc(2);
    chk("stretch load", STRETCH_COUNT, 32'h5);
    cyc(TICK + 1);
    chk("stretch step", STRETCH_COUNT, 32'h4);
    cyc(TICK * 5);
    chk("stretch end", STRETCH_COUNT, 32'h0);
    STRETCH_LOAD_VALUE = 10'h3FF;
    STRETCH_LOAD = 1'b1;
    cyc(1);
    STRETCH_LOAD = 1'b0;
    SAFING_STATE_RESET = 1'b1;
    cyc(1);
    SAFING_STATE_RESET = 1'b0;
    cyc(3);
    chk("stretch ssr", STRETCH_COUNT, 32'h0);
  endtask : t_stretch
  initial begin
    cyc(16);
    RESET_N = 1'b1;
    cyc(4);
    t_defaults();
    t_loops();
    t_crash();
    t_status();
    t_stretch();
    results();
  end
endmodule : tb_top
